// *** rtl/sild_pkg.sv ***
// Package of constants and types shared by the status indicator LED driver.
package sild_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // Flash rates are held in millihertz so that 2.5 Hz stays an integer.
    localparam int SLOW_FLASH_MHZ = 2500;
    localparam int FAST_FLASH_MHZ = 10000;
    localparam int SLOW_HALF_MS = 1000000 / (2 * SLOW_FLASH_MHZ);
    localparam int FAST_HALF_MS = 1000000 / (2 * FAST_FLASH_MHZ);
    localparam int PULSE_ON_MS = 200;
    localparam int PULSE_GAP_MS = 200;
    localparam int PULSE_OFF_MS = 1000;
    localparam int SINGLE_FRAME_MS = PULSE_ON_MS + PULSE_OFF_MS;
    localparam int DOUBLE_FRAME_MS = 2 * PULSE_ON_MS + PULSE_GAP_MS + PULSE_OFF_MS;
    localparam int HOUR_MS = 3600000;
    localparam int MS_CNT_W = 11;
    localparam int HOUR_CNT_W = 22;

    // Communication state codes as presented by the state machine logic.
    localparam logic [3:0] AL_INIT = 4'h1;
    localparam logic [3:0] AL_PREOP = 4'h2;
    localparam logic [3:0] AL_BOOT = 4'h3;
    localparam logic [3:0] AL_SAFEOP = 4'h4;
    localparam logic [3:0] AL_OP = 4'h8;

    typedef enum {RUN_OFF, RUN_SLOW, RUN_SINGLE, RUN_ON, RUN_FAST} sild_run_mode_t;

    // Object dictionary indices.
    localparam logic [15:0] OBJ_DEVICE_TYPE = 16'h1000;
    localparam logic [15:0] OBJ_SM_TYPES = 16'h1C00;
    localparam logic [15:0] OBJ_SM0_PDO = 16'h1C10;
    localparam logic [15:0] OBJ_SM1_PDO = 16'h1C11;
    localparam logic [15:0] OBJ_SM3_PDO = 16'h1C13;
    localparam logic [15:0] OBJ_INSTALL_LOC = 16'h2007;
    localparam logic [15:0] OBJ_OP_HOURS = 16'h2008;
    localparam logic [15:0] OBJ_EQUIP_ID = 16'h200A;
    localparam logic [15:0] OBJ_FACTORY_RESET = 16'h2F00;
    localparam logic [15:0] OBJ_INPUTS = 16'h4000;
    localparam logic [15:0] OBJ_IO_STATUS = 16'h4001;
    localparam logic [15:0] OBJ_TX_MAP_INPUTS = 16'h1A00;

    localparam logic [31:0] DEVICE_TYPE_VAL = 32'h0000_0000;
    localparam logic [7:0] SM_COUNT = 8'h04;
    localparam logic [7:0] SM3_PDO_COUNT = 8'h01;
    localparam logic [7:0] INPUT_BYTES = 8'h02;
    localparam logic [7:0] IO_STATUS_ENTRIES = 8'h01;
    localparam logic [7:0] FRESET_NORMAL = 8'h00;
    localparam logic [7:0] FRESET_DEVICE = 8'h01;

    // Identification switch limits.
    localparam logic [7:0] ID_MIN = 8'h01;
    localparam logic [7:0] ID_MAX = 8'h9F;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [1:0] STARTUP_WAIT = 2'h3;

    // Input synchroniser width: 16 inputs, 2 links, 8 switch bits, 5 monitors.
    localparam int SYNC_W = 31;

endpackage : sild_pkg

// *** rtl/sild_sync.sv ***
// Two flip-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module sild_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule : sild_sync

// *** rtl/sild_pattern_gen.sv ***
// Millisecond based flash and pulse pattern generator for the indicators.
`timescale 1ns/1ps
module sild_pattern_gen
    import sild_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ms_tick_i,
    output logic slow_o,
    output logic fast_o,
    output logic single_o,
    output logic double_o
);
    logic [MS_CNT_W-1:0] slow_cnt_reg;
    logic [MS_CNT_W-1:0] fast_cnt_reg;
    logic [MS_CNT_W-1:0] single_cnt_reg;
    logic [MS_CNT_W-1:0] double_cnt_reg;

    // Half periods give the flashes an even duty cycle.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slow_cnt_reg <= '0;
            slow_o <= 1'b0;
        end else if (ms_tick_i) begin
            if (slow_cnt_reg == MS_CNT_W'(SLOW_HALF_MS - 1)) begin
                slow_cnt_reg <= '0;
                slow_o <= !slow_o;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fast_cnt_reg <= '0;
            fast_o <= 1'b0;
        end else if (ms_tick_i) begin
            if (fast_cnt_reg == MS_CNT_W'(FAST_HALF_MS - 1)) begin
                fast_cnt_reg <= '0;
                fast_o <= !fast_o;
            end else begin
                fast_cnt_reg <= fast_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            single_cnt_reg <= '0;
            double_cnt_reg <= '0;
        end else if (ms_tick_i) begin
            single_cnt_reg <= (single_cnt_reg == MS_CNT_W'(SINGLE_FRAME_MS - 1)) ? '0
                : single_cnt_reg + 1'b1;
            double_cnt_reg <= (double_cnt_reg == MS_CNT_W'(DOUBLE_FRAME_MS - 1)) ? '0
                : double_cnt_reg + 1'b1;
        end
    end

    assign single_o = single_cnt_reg < MS_CNT_W'(PULSE_ON_MS);
    assign double_o = (double_cnt_reg < MS_CNT_W'(PULSE_ON_MS)) ||
        ((double_cnt_reg >= MS_CNT_W'(PULSE_ON_MS + PULSE_GAP_MS)) &&
        (double_cnt_reg < MS_CNT_W'(2 * PULSE_ON_MS + PULSE_GAP_MS)));

    property p_slow_on_tick;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $changed(slow_o) |-> $past(ms_tick_i) &&
        ($past(slow_cnt_reg) == MS_CNT_W'(SLOW_HALF_MS - 1));
    endproperty
    a_slow_on_tick: assert property (p_slow_on_tick) else $error("slow flash toggled off phase");

    property p_double_gap;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (double_cnt_reg >= MS_CNT_W'(PULSE_ON_MS) &&
        double_cnt_reg < MS_CNT_W'(PULSE_ON_MS + PULSE_GAP_MS)) |-> !double_o;
    endproperty
    a_double_gap: assert property (p_double_gap) else $error("double pulse lit in gap");

endmodule : sild_pattern_gen

// *** rtl/sild_top.sv ***
// Front panel status indicator driver with its object dictionary access port.
//
// Notes on behaviour
// - Link LED green while either port linked.
// - Ready LED steady green once started.
// - Firmware update flashes ready LED yellow.
// - Supply or temperature fault alternates green/yellow.
// - Sensor overload alternates too, supply LED red.
// - Invalid switch code lights ready red.
// - Ready LED dark while not ready; code still lights it for update, switch error or supply alarm.
// - Run LED off in Init.
// - Run LED blinks 2.5 Hz in Pre-Operational.
// - Safe-Operational: 200 ms on, 1000 ms off.
// - Run LED steady in Operational.
// - Run LED flashes 10 Hz in Bootstrap.
// - Error LED red on critical error.
// - Error LED blinks 2.5 Hz on configuration error.
// - Watchdog double pulse, application error single pulse.
// - Supply LED green, off, or red overload.
// - Input LEDs yellow while input set.
// - Objects reachable through mailbox service transfers.
// - Index plus subindex; subindex 0 gives count.
// - Object SM3_PDO_ASSIGNMENT reports inputs on sync manager 3.
// - Factory reset and two text objects writable.
// - Codes outside 01..159 flagged, old identification kept.
`timescale 1ns/1ps
module sild_top
    import sild_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] di_pin_i,
    input wire logic link_port_in_i,
    input wire logic link_port_out_i,
    input wire logic [3:0] switch_tens_i,
    input wire logic [3:0] switch_ones_i,
    input wire logic sensor_supply_ok_i,
    input wire logic supply_window_fault_i,
    input wire logic sensor_overload_i,
    input wire logic actuator_supply_ok_i,
    input wire logic temp_critical_i,
    input wire logic device_ready_i,
    input wire logic fw_update_i,
    input wire logic [3:0] al_state_i,
    input wire logic crit_error_i,
    input wire logic config_error_i,
    input wire logic wdog_expired_i,
    input wire logic app_error_i,
    input wire logic [7:0] prev_ident_i,
    input wire logic obj_req_i,
    input wire logic obj_wr_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0] obj_subindex_i,
    input wire logic [31:0] obj_wdata_i,
    output logic obj_ack_o,
    output logic obj_abort_o,
    output logic [31:0] obj_rdata_o,
    output logic text_obj_wr_o,
    output logic factory_reset_o,
    output logic [7:0] ident_value_o,
    output logic link_led_o,
    output logic ready_green_o,
    output logic ready_yellow_o,
    output logic ready_red_o,
    output logic run_led_o,
    output logic err_led_o,
    output logic sensor_supply_led_green_o,
    output logic sensor_supply_led_red_o,
    output logic actuator_supply_led_o,
    output logic [15:0] input_led_o
);
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_s;
    logic [15:0] di_s;
    logic [1:0] link_s;
    logic [3:0] tens_s;
    logic [3:0] ones_s;
    logic sensor_ok_s;
    logic window_fault_s;
    logic overload_s;
    logic actuator_ok_s;
    logic temp_crit_s;
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
    logic ms_tick;
    logic slow_ph;
    logic fast_ph;
    logic single_ph;
    logic double_ph;
    logic [1:0] startup_reg;
    logic captured_reg;
    logic switch_invalid_reg;
    logic [7:0] switch_code;
    logic switch_ok;
    logic supply_alarm;
    sild_run_mode_t run_mode;
    logic [HOUR_CNT_W-1:0] hour_ms_reg;
    logic [31:0] op_hours_reg;
    logic [7:0] freset_reg;
    logic [31:0] io_status;
    logic [31:0] rd_val;
    logic rd_hit;
    logic wr_text;

    assign pins_async = {di_pin_i, link_port_out_i, link_port_in_i, switch_tens_i,
        switch_ones_i, sensor_supply_ok_i, supply_window_fault_i, sensor_overload_i,
        actuator_supply_ok_i, temp_critical_i};

    sild_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(pins_async),
        .sync_o(pins_s)
    );

    assign {di_s, link_s, tens_s, ones_s, sensor_ok_s, window_fault_s, overload_s,
        actuator_ok_s, temp_crit_s} = pins_s;

    // One millisecond tick; shorten TICK_CYCLES to speed up simulation.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_reg <= '0;
        end else if (ms_tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    assign ms_tick = tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

    sild_pattern_gen u_pattern (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ms_tick_i(ms_tick),
        .slow_o(slow_ph),
        .fast_o(fast_ph),
        .single_o(single_ph),
        .double_o(double_ph)
    );

    function automatic sild_run_mode_t run_mode_of(input logic [3:0] st);
        case (st)
            AL_PREOP: run_mode_of = RUN_SLOW;
            AL_SAFEOP: run_mode_of = RUN_SINGLE;
            AL_OP: run_mode_of = RUN_ON;
            AL_BOOT: run_mode_of = RUN_FAST;
            default: run_mode_of = RUN_OFF;
        endcase
    endfunction : run_mode_of

    // Switch code is tens times ten plus ones, read once after reset release.
    assign switch_code = {1'b0, tens_s, 3'b000} + {3'b000, tens_s, 1'b0} + {4'h0, ones_s};
    assign switch_ok = (ones_s <= DIGIT_MAX) && (switch_code >= ID_MIN) &&
        (switch_code <= ID_MAX);

    // Waiting a few cycles lets the synchroniser fill before the switches are caught.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            startup_reg <= '0;
            captured_reg <= 1'b0;
            switch_invalid_reg <= 1'b0;
            ident_value_o <= 8'h00;
        end else if (!captured_reg) begin
            if (startup_reg == STARTUP_WAIT) begin
                captured_reg <= 1'b1;
                switch_invalid_reg <= !switch_ok;
                ident_value_o <= switch_ok ? switch_code : prev_ident_i;
            end else begin
                startup_reg <= startup_reg + 1'b1;
            end
        end
    end

    assign supply_alarm = window_fault_s || temp_crit_s || overload_s;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_led_o <= 1'b0;
            input_led_o <= '0;
            sensor_supply_led_green_o <= 1'b0;
            sensor_supply_led_red_o <= 1'b0;
            actuator_supply_led_o <= 1'b0;
        end else begin
            link_led_o <= |link_s;
            input_led_o <= di_s;
            sensor_supply_led_red_o <= overload_s;
            sensor_supply_led_green_o <= sensor_ok_s && !overload_s;
            actuator_supply_led_o <= actuator_ok_s;
        end
    end

    // Update indication outranks the switch error, which outranks supply alarms.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_green_o <= 1'b0;
            ready_yellow_o <= 1'b0;
            ready_red_o <= 1'b0;
        end else if (fw_update_i) begin
            ready_green_o <= 1'b0;
            ready_yellow_o <= slow_ph;
            ready_red_o <= 1'b0;
        end else if (captured_reg && switch_invalid_reg) begin
            ready_green_o <= 1'b0;
            ready_yellow_o <= 1'b0;
            ready_red_o <= 1'b1;
        end else if (supply_alarm) begin
            ready_green_o <= slow_ph;
            ready_yellow_o <= !slow_ph;
            ready_red_o <= 1'b0;
        end else begin
            ready_green_o <= device_ready_i && captured_reg;
            ready_yellow_o <= 1'b0;
            ready_red_o <= 1'b0;
        end
    end

    assign run_mode = run_mode_of(al_state_i);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_led_o <= 1'b0;
        end else begin
            unique case (run_mode)
                RUN_OFF: run_led_o <= 1'b0;
                RUN_SLOW: run_led_o <= slow_ph;
                RUN_SINGLE: run_led_o <= single_ph;
                RUN_ON: run_led_o <= 1'b1;
                RUN_FAST: run_led_o <= fast_ph;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_led_o <= 1'b0;
        end else if (crit_error_i) begin
            err_led_o <= 1'b1;
        end else if (wdog_expired_i) begin
            err_led_o <= double_ph;
        end else if (config_error_i) begin
            err_led_o <= slow_ph;
        end else if (app_error_i) begin
            err_led_o <= single_ph;
        end else begin
            err_led_o <= 1'b0;
        end
    end

    // Operating hours count whole hours of powered time.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hour_ms_reg <= '0;
            op_hours_reg <= '0;
        end else if (ms_tick) begin
            if (hour_ms_reg == HOUR_CNT_W'(HOUR_MS - 1)) begin
                hour_ms_reg <= '0;
                op_hours_reg <= op_hours_reg + 1'b1;
            end else begin
                hour_ms_reg <= hour_ms_reg + 1'b1;
            end
        end
    end

    assign io_status = {26'h0, switch_invalid_reg, temp_crit_s, window_fault_s,
        actuator_ok_s, overload_s, sensor_ok_s};

    // Single entry objects accept subindex 0 only; lists answer their count there.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (obj_index_i)
            OBJ_DEVICE_TYPE: begin
                rd_val = DEVICE_TYPE_VAL;
                rd_hit = obj_subindex_i == 8'h00;
            end
            OBJ_SM_TYPES: begin
                rd_val = (obj_subindex_i == 8'h00) ? {24'h0, SM_COUNT}
                    : {24'h0, obj_subindex_i};
                rd_hit = obj_subindex_i <= SM_COUNT;
            end
            OBJ_SM0_PDO, OBJ_SM1_PDO: begin
                rd_hit = obj_subindex_i == 8'h00;
            end
            OBJ_SM3_PDO: begin
                rd_val = (obj_subindex_i == 8'h00) ? {24'h0, SM3_PDO_COUNT}
                    : {16'h0, OBJ_TX_MAP_INPUTS};
                rd_hit = obj_subindex_i <= SM3_PDO_COUNT;
            end
            OBJ_OP_HOURS: begin
                rd_val = op_hours_reg;
                rd_hit = obj_subindex_i == 8'h00;
            end
            OBJ_FACTORY_RESET: begin
                rd_val = {24'h0, freset_reg};
                rd_hit = obj_subindex_i == 8'h00;
            end
            OBJ_INPUTS: begin
                rd_val = (obj_subindex_i == 8'h00) ? {24'h0, INPUT_BYTES}
                    : (obj_subindex_i == 8'h01) ? {24'h0, di_s[7:0]}
                    : {24'h0, di_s[15:8]};
                rd_hit = obj_subindex_i <= INPUT_BYTES;
            end
            OBJ_IO_STATUS: begin
                rd_val = (obj_subindex_i == 8'h00) ? {24'h0, IO_STATUS_ENTRIES} : io_status;
                rd_hit = obj_subindex_i <= IO_STATUS_ENTRIES;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign wr_text = ((obj_index_i == OBJ_INSTALL_LOC) || (obj_index_i == OBJ_EQUIP_ID));

    // Every request is answered on the next edge; refused ones carry the abort flag.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            obj_ack_o <= 1'b0;
            obj_abort_o <= 1'b0;
            obj_rdata_o <= '0;
            text_obj_wr_o <= 1'b0;
            freset_reg <= FRESET_NORMAL;
        end else begin
            obj_ack_o <= obj_req_i;
            obj_abort_o <= 1'b0;
            text_obj_wr_o <= 1'b0;
            if (obj_req_i && !obj_wr_i) begin
                obj_rdata_o <= rd_hit ? rd_val : 32'h0000_0000;
                obj_abort_o <= !rd_hit;
            end else if (obj_req_i) begin
                obj_rdata_o <= 32'h0000_0000;
                if (obj_index_i == OBJ_FACTORY_RESET && obj_subindex_i == 8'h00 &&
                    obj_wdata_i[7:0] <= FRESET_DEVICE) begin
                    freset_reg <= obj_wdata_i[7:0];
                end else if (wr_text) begin
                    text_obj_wr_o <= 1'b1;
                end else begin
                    obj_abort_o <= 1'b1;
                end
            end
        end
    end

    assign factory_reset_o = freset_reg == FRESET_DEVICE;

    property p_link;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (link_s == 2'b00) |=> !link_led_o;
    endproperty
    a_link: assert property (p_link) else $error("link LED lit without link");

    property p_ready_green;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (captured_reg && !switch_invalid_reg && !fw_update_i && !supply_alarm && device_ready_i)
        |=> ready_green_o && !ready_yellow_o && !ready_red_o;
    endproperty
    a_ready_green: assert property (p_ready_green) else $error("ready LED not green");

    property p_fw_yellow;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        fw_update_i |=> !ready_green_o && !ready_red_o && (ready_yellow_o == $past(slow_ph));
    endproperty
    a_fw_yellow: assert property (p_fw_yellow) else $error("update flash wrong");

    property p_invalid_red;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (captured_reg && switch_invalid_reg && !fw_update_i) |=> ready_red_o && !ready_green_o;
    endproperty
    a_invalid_red: assert property (p_invalid_red) else $error("invalid switch not red");

    property p_run_init;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (al_state_i == AL_INIT) [*2] |=> !run_led_o;
    endproperty
    a_run_init: assert property (p_run_init) else $error("run LED lit in init");

    property p_err_order;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!crit_error_i && wdog_expired_i && config_error_i) |=> err_led_o == $past(double_ph);
    endproperty
    a_err_order: assert property (p_err_order) else $error("error LED priority wrong");

    property p_inputs;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(captured_reg) |-> ##3 input_led_o == $past(di_pin_i, 3);
    endproperty
    a_inputs: assert property (p_inputs) else $error("input LEDs lag wrong");

    property p_sm3;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (obj_req_i && !obj_wr_i && obj_index_i == 16'h1C13 && obj_subindex_i == 8'h01)
        |=> obj_ack_o && !obj_abort_o && obj_rdata_o == 32'h0000_1A00;
    endproperty
    a_sm3: assert property (p_sm3) else $error("sync manager 3 object wrong");

    property p_ident;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(captured_reg) |-> ident_value_o == (switch_invalid_reg ? $past(prev_ident_i)
        : $past(switch_code)) && switch_invalid_reg == !$past(switch_ok);
    endproperty
    a_ident: assert property (p_ident) else $error("identification capture wrong");

endmodule : sild_top

// *** testbench/sild_led_panel.sv ***
// Front panel model that counts the lit cycles of the run and error lamps.
`timescale 1ns/1ps
module sild_led_panel (
    input wire logic sys_clk_i,
    input wire logic clear_i,
    input wire logic run_led_i,
    input wire logic err_led_i,
    output logic [31:0] run_lit_o,
    output logic [31:0] err_lit_o
);
    // A lamp only integrates light, so a lit count over whole frames is what an eye sees.
    always @(posedge sys_clk_i) begin
        run_lit_o <= clear_i ? 32'h0 : run_lit_o + {31'h0, run_led_i};
        err_lit_o <= clear_i ? 32'h0 : err_lit_o + {31'h0, err_led_i};
    end
endmodule : sild_led_panel

// *** testbench/testbench.sv ***
// Self-checking bench for the status indicator LED driver.
`timescale 1ns/1ps
module testbench;
    import sild_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic lk_in, lk_out, s_ok, win, ovl, a_ok, temp, rdy, fw, crit, cfg, wdog, app, req, wr, clr;
    logic ack, abrt, txt, frst, lk_led, rg, ry, rr, run, err, sg, sr, aled;
    logic [15:0] di, idx, in_led;
    logic [3:0] tens, ones, al;
    logic [7:0] prev, sub, ident;
    logic [31:0] wdata, rdata, run_lit, err_lit;
    int failures = 0;
    int tests_run = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    sild_top #(.TICK_CYCLES(4)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .di_pin_i(di),
        .link_port_in_i(lk_in), .link_port_out_i(lk_out), .switch_tens_i(tens),
        .switch_ones_i(ones), .sensor_supply_ok_i(s_ok), .supply_window_fault_i(win),
        .sensor_overload_i(ovl), .actuator_supply_ok_i(a_ok), .temp_critical_i(temp),
        .device_ready_i(rdy), .fw_update_i(fw), .al_state_i(al), .crit_error_i(crit),
        .config_error_i(cfg), .wdog_expired_i(wdog), .app_error_i(app), .prev_ident_i(prev),
        .obj_req_i(req), .obj_wr_i(wr), .obj_index_i(idx), .obj_subindex_i(sub),
        .obj_wdata_i(wdata), .obj_ack_o(ack), .obj_abort_o(abrt), .obj_rdata_o(rdata),
        .text_obj_wr_o(txt), .factory_reset_o(frst), .ident_value_o(ident), .link_led_o(lk_led),
        .ready_green_o(rg), .ready_yellow_o(ry), .ready_red_o(rr), .run_led_o(run),
        .err_led_o(err), .sensor_supply_led_green_o(sg), .sensor_supply_led_red_o(sr),
        .actuator_supply_led_o(aled), .input_led_o(in_led));
    sild_led_panel i_panel (.sys_clk_i(sys_clk_i), .clear_i(clr), .run_led_i(run),
        .err_led_i(err), .run_lit_o(run_lit), .err_lit_o(err_lit));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    // The request is a one-cycle pulse; the answer always lands on the following edge.
    task automatic obj(input logic w, input logic [15:0] i, input logic [7:0] s, input logic ab);
        {req, wr, idx, sub, wdata} = {1'b1, w, i, s, 32'h1};
        cyc(1);
        check("obj_ack", 32'h1, {31'h0, ack});
        check("obj_abort", {31'h0, ab}, {31'h0, abrt});
        req = 1'b0;
        cyc(1);
    endtask : obj
    task automatic lit(input int ms, input logic [31:0] e_run, input logic [31:0] e_err);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(ms * 4);
        check("run_lit", e_run, run_lit);
        check("err_lit", e_err, err_lit);
    endtask : lit
    // One whole slow period is sampled, so the lit count does not depend on phase.
    task automatic fw_flash;
        int yel = 0;
        int bad = 0;
        fw = 1'b1;
        cyc(1);
        repeat (1600) begin
            yel += ry;
            bad += rr | rg;
            cyc(1);
        end
        check("fw_yellow", 32'h320, yel);
        check("fw_no_red_green", 32'h0, bad);
        fw = 1'b0;
    endtask : fw_flash
    task automatic final_report;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {lk_in, lk_out, s_ok, win, ovl, a_ok, temp, fw, crit, cfg, wdog, app, req, wr, clr} = '0;
        {rdy, tens, ones, prev, al} = {1'b1, 4'h1, 4'h2, 8'h07, AL_INIT};
        {di, idx, sub, wdata} = '0;
        cyc(2);
        rst_b_i = 1'b1;
        cyc(3);
        check("ready_dark", 32'h0, {31'h0, rg});
        cyc(3);
        check("ident", 32'hC, {24'h0, ident});
        check("ready_green", 32'h1, {31'h0, rg});
        {lk_out, a_ok, di, s_ok, ovl} = {2'b11, 16'hA5C3, 2'b11};
        cyc(3);
        check("link_led", 32'h1, {31'h0, lk_led});
        check("input_led", 32'hA5C3, {16'h0, in_led});
        check("supply_led", 32'h1, {30'h0, sg, sr});
        check("actuator_led", 32'h1, {31'h0, aled});
        check("ready_alt", 32'h1, {30'h0, rr, rg ^ ry});
        obj(1'b0, 16'h1C13, 8'h01, 1'b0);
        check("sm3_map", 32'h1A00, rdata);
        obj(1'b0, 16'h1C13, 8'h00, 1'b0);
        check("sm3_count", 32'h1, rdata);
        obj(1'b1, 16'h1000, 8'h00, 1'b1);
        obj(1'b1, 16'h2F00, 8'h00, 1'b0);
        check("factory_reset", 32'h1, {31'h0, frst});
        lit(1200, 0, 0);
        al = AL_PREOP;
        lit(1200, 2400, 0);
        al = AL_SAFEOP;
        lit(1200, 800, 0);
        al = AL_BOOT;
        lit(1200, 2400, 0);
        {al, cfg, app} = {AL_OP, 2'b11};
        lit(1200, 4800, 2400);
        wdog = 1'b1;
        lit(1600, 6400, 1600);
        crit = 1'b1;
        lit(1600, 6400, 6400);
        {crit, wdog, cfg} = 3'b000;
        lit(1200, 4800, 800);
        {tens, ones, ovl} = 9'h0;
        rst_b_i = 1'b0;
        cyc(2);
        rst_b_i = 1'b1;
        cyc(6);
        check("ident_kept", 32'h7, {24'h0, ident});
        check("ready_red", 32'h4, {29'h0, rr, rg, ry});
        fw_flash();
        final_report();
    end
endmodule : testbench
